// ==== mic_cmp.sv ====
// Threshold comparator for one axis value against the two limits.
// Assumes the value is two's complement of width W, W at least 13.
`timescale 1ns/10ps

module mic_cmp
    import mic_pkg::*;
#(
    parameter int W = 13,
    parameter bit SKIP_SAT = 1'b1
)
(
    // Axis value
    input wire logic [W-1:0] value,
    input wire logic [W-1:0] sat_code,
    // Limits
    input wire logic [7:0] lower_limit,
    input wire logic [7:0] upper_limit,
    // Results
    output logic below,
    output logic above
);

    // Sign-extend the limit, then scale by sixteen
    function automatic logic signed [W-1:0] scale_limit(input logic [7:0] lim);
        logic signed [W-1:0] ext;
        ext = W'(signed'(lim));
        scale_limit = ext <<< MIC_THR_SHIFT;
    endfunction : scale_limit

    logic signed [W-1:0] sval;
    logic is_sat;

    always_comb
    begin
        sval = signed'(value);
        is_sat = SKIP_SAT && (value == sat_code);
        below = (sval < scale_limit(lower_limit)) && !is_sat;
        above = sval > scale_limit(upper_limit);
    end

endmodule : mic_cmp

// ==== mic_ctrl.sv ====
// Magnetometer interrupt controller: threshold, overflow and new-sample
// engines, status flags and the two interrupt pins.
// Assumes a byte register port from the serial interface and a one-cycle
// store pulse from the measurement sequencer with a full sample set.
`timescale 1ns/10ps

module mic_ctrl
    import mic_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Measurement sequencer
    input wire logic sample_store,
    input wire logic [MIC_XY_W-1:0] raw_x,
    input wire logic [MIC_XY_W-1:0] raw_y,
    input wire logic [MIC_Z_W-1:0] raw_z,
    input wire logic [MIC_RES_W-1:0] raw_res,
    input wire logic [2:0] axis_ovf,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Transaction end: stop condition or chip select rising
    input wire logic xfer_end,
    // Stored field data
    output logic [MIC_XY_W-1:0] field_x_value,
    output logic [MIC_XY_W-1:0] field_y_value,
    output logic [MIC_Z_W-1:0] field_z_value,
    output logic [MIC_RES_W-1:0] plate_resistance_value,
    // Interrupt pins
    output logic int_pin_o,
    output logic int_pin_oe,
    output logic new_sample_pin_o,
    output logic new_sample_pin_oe
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [MIC_XY_W-1:0] x;
        logic [MIC_XY_W-1:0] y;
        logic [MIC_Z_W-1:0] z;
        logic [MIC_RES_W-1:0] res;
        logic [7:0] ctrl;
        logic [7:0] pin;
        logic [7:0] lower;
        logic [7:0] upper;
        logic [2:0] low_flg;
        logic [2:0] high_flg;
        logic ovf_flg;
        logic new_flg;
        logic data_read;
        logic [7:0] rdata;
        logic int_o;
        logic new_o;
    } mic_state_t;

    mic_state_t st_r;
    mic_state_t st_nxt;

    // ************************************************************
    // Comparators on the incoming sample
    // ************************************************************
    logic [MIC_XY_W-1:0] sat_x;
    logic [MIC_XY_W-1:0] sat_y;
    logic [MIC_Z_W-1:0] sat_z;
    logic [2:0] below;
    logic [2:0] above;

    always_comb
    begin
        sat_x = axis_ovf[0] ? MIC_XY_SAT : raw_x;
        sat_y = axis_ovf[1] ? MIC_XY_SAT : raw_y;
        sat_z = axis_ovf[2] ? MIC_Z_SAT : raw_z;
    end

    mic_cmp #(.W(MIC_XY_W), .SKIP_SAT(1'b1)) u_cmp_x (
        .value(sat_x), .sat_code(MIC_XY_SAT),
        .lower_limit(st_r.lower), .upper_limit(st_r.upper),
        .below(below[0]), .above(above[0])
    );
    mic_cmp #(.W(MIC_XY_W), .SKIP_SAT(1'b1)) u_cmp_y (
        .value(sat_y), .sat_code(MIC_XY_SAT),
        .lower_limit(st_r.lower), .upper_limit(st_r.upper),
        .below(below[1]), .above(above[1])
    );
    // Z saturation is not excluded from the low compare
    mic_cmp #(.W(MIC_Z_W), .SKIP_SAT(1'b0)) u_cmp_z (
        .value(sat_z), .sat_code(MIC_Z_SAT),
        .lower_limit(st_r.lower), .upper_limit(st_r.upper),
        .below(below[2]), .above(above[2])
    );

    // ************************************************************
    // Next state
    // ************************************************************
    logic [2:0] low_en;
    logic [2:0] high_en;
    logic ovf_en;
    logic latched;
    logic flags_rd;
    logic data_rd;
    logic int_act;

    always_comb
    begin
        st_nxt = st_r;
        low_en = ~st_r.ctrl[MIC_CTRL_AXIS_LO +: 3];
        high_en = ~st_r.ctrl[MIC_CTRL_AXIS_HI +: 3];
        ovf_en = st_r.ctrl[MIC_CTRL_OVF_EN];
        latched = st_r.pin[MIC_PIN_LATCH];
        flags_rd = reg_rd && (reg_addr == MIC_ADDR_FLAGS);
        data_rd = reg_rd && (reg_addr >= MIC_ADDR_DATA_LO)
            && (reg_addr < MIC_ADDR_FLAGS);

        // Register writes; data and status are read-only
        if (reg_wr)
        begin
            case (reg_addr)
                MIC_ADDR_CTRL: st_nxt.ctrl = reg_wdata;
                MIC_ADDR_PIN: st_nxt.pin = reg_wdata;
                MIC_ADDR_LOWER: st_nxt.lower = reg_wdata;
                MIC_ADDR_UPPER: st_nxt.upper = reg_wdata;
                default: st_nxt.ctrl = st_r.ctrl;
            endcase
        end

        // Latched flags drop on a status read; a store in the same cycle wins
        if (flags_rd && latched)
        begin
            st_nxt.low_flg = '0;
            st_nxt.high_flg = '0;
            st_nxt.ovf_flg = 1'b0;
        end

        // New-sample flag clears once a data read is closed by transaction end
        if (data_rd)
            st_nxt.data_read = 1'b1;
        if (xfer_end && (st_r.data_read || data_rd))
        begin
            st_nxt.data_read = 1'b0;
            st_nxt.new_flg = 1'b0;
        end

        if (sample_store)
        begin
            st_nxt.x = sat_x;
            st_nxt.y = sat_y;
            st_nxt.z = sat_z;
            st_nxt.res = raw_res;
            st_nxt.new_flg = 1'b1;
            // Disabled sources clear, enabled ones follow or accumulate
            if (latched)
            begin
                st_nxt.low_flg = (st_nxt.low_flg | below) & low_en;
                st_nxt.high_flg = (st_nxt.high_flg | above) & high_en;
                st_nxt.ovf_flg = (st_nxt.ovf_flg | (|axis_ovf)) & ovf_en;
            end
            else
            begin
                st_nxt.low_flg = below & low_en;
                st_nxt.high_flg = above & high_en;
                st_nxt.ovf_flg = (|axis_ovf) & ovf_en;
            end
        end

        // Pin levels come from the flags as they will stand next cycle
        int_act = (|st_nxt.low_flg) | (|st_nxt.high_flg) | st_nxt.ovf_flg;
        st_nxt.int_o = ~(int_act ^ st_nxt.pin[MIC_PIN_INT_POL]);
        st_nxt.new_o = ~(st_nxt.new_flg ^ st_nxt.pin[MIC_PIN_NEW_POL]);

        // Read data
        case (reg_addr)
            MIC_ADDR_RES_LSB: st_nxt.rdata = {st_r.res[5:0], 1'b0, st_r.new_flg};
            MIC_ADDR_FLAGS: st_nxt.rdata = {1'b0, st_r.ovf_flg, st_r.high_flg, st_r.low_flg};
            MIC_ADDR_CTRL: st_nxt.rdata = st_r.ctrl;
            MIC_ADDR_PIN: st_nxt.rdata = st_r.pin;
            MIC_ADDR_LOWER: st_nxt.rdata = st_r.lower;
            MIC_ADDR_UPPER: st_nxt.rdata = st_r.upper;
            default: st_nxt.rdata = 8'h00;
        endcase

        if (rst)
        begin
            st_nxt = '0;
            st_nxt.ctrl = MIC_CTRL_RST;
            st_nxt.pin = MIC_PIN_RST;
            st_nxt.lower = MIC_LIMIT_RST;
            st_nxt.upper = MIC_LIMIT_RST;
        end
    end

    always_ff @(posedge clk)
    begin
        st_r <= st_nxt;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign reg_rdata = st_r.rdata;
    assign field_x_value = st_r.x;
    assign field_y_value = st_r.y;
    assign field_z_value = st_r.z;
    assign plate_resistance_value = st_r.res;
    assign int_pin_o = st_r.int_o;
    assign int_pin_oe = st_r.pin[MIC_PIN_INT_EN];
    assign new_sample_pin_o = st_r.new_o;
    assign new_sample_pin_oe = st_r.pin[MIC_PIN_NEW_EN];

endmodule : mic_ctrl

// ==== mic_ctrl_properties.sv ====
// Port checker for the magnetometer interrupt controller.
// Assumes it is bound to mic_ctrl and sees only its ports.
`timescale 1ns/10ps

module mic_chk
    import mic_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Sequencer and register port
    input wire logic sample_store,
    input wire logic [MIC_XY_W-1:0] raw_y,
    input wire logic [2:0] axis_ovf,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    // Stored data and pins
    input wire logic [MIC_XY_W-1:0] field_x_value,
    input wire logic [MIC_XY_W-1:0] field_y_value,
    input wire logic [MIC_Z_W-1:0] field_z_value,
    input wire logic int_pin_o,
    input wire logic int_pin_oe,
    input wire logic new_sample_pin_o,
    input wire logic new_sample_pin_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Shadow of the polarity and latch bits, so pin levels can be judged
    logic new_pol_r, latch_r, int_pol_r;
    always_ff @(posedge clk)
    begin
        if (rst)
            {new_pol_r, latch_r, int_pol_r} <= 3'h7;
        else if (reg_wr && reg_addr == MIC_ADDR_PIN)
            {new_pol_r, latch_r, int_pol_r} <= reg_wdata[2:0];
    end

    property p_rst_float;
        $fell(rst) |-> !int_pin_oe && !new_sample_pin_oe;
    endproperty
    a_rst_float: assert property (p_rst_float) else $error("pin driven after reset");
    property p_int_oe;
        reg_wr && reg_addr == MIC_ADDR_PIN |=> int_pin_oe == $past(reg_wdata[6]);
    endproperty
    a_int_oe: assert property (p_int_oe) else $error("int pin enable wrong");
    property p_new_oe;
        reg_wr && reg_addr == MIC_ADDR_PIN |=> new_sample_pin_oe == $past(reg_wdata[7]);
    endproperty
    a_new_oe: assert property (p_new_oe) else $error("new pin enable wrong");
    property p_sat_x;
        sample_store && axis_ovf[0] |=> field_x_value == MIC_XY_SAT;
    endproperty
    a_sat_x: assert property (p_sat_x) else $error("x not saturated");
    property p_sat_z;
        sample_store && axis_ovf[2] |=> field_z_value == MIC_Z_SAT;
    endproperty
    a_sat_z: assert property (p_sat_z) else $error("z not saturated");
    property p_store_y;
        sample_store && !axis_ovf[1] |=> field_y_value == $past(raw_y);
    endproperty
    a_store_y: assert property (p_store_y) else $error("y not stored");
    property p_new_pin;
        sample_store && !reg_wr |=> new_sample_pin_o == new_pol_r;
    endproperty
    a_new_pin: assert property (p_new_pin) else $error("new pin not active");
    property p_latch_clr;
        reg_rd && reg_addr == MIC_ADDR_FLAGS && latch_r && !sample_store && !reg_wr
            |=> int_pin_o == !int_pol_r;
    endproperty
    a_latch_clr: assert property (p_latch_clr) else $error("int pin not released");
endmodule : mic_chk

bind mic_ctrl mic_chk u_mic_chk (
    .clk(clk), .rst(rst), .sample_store(sample_store), .raw_y(raw_y), .axis_ovf(axis_ovf),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .field_x_value(field_x_value), .field_y_value(field_y_value),
    .field_z_value(field_z_value), .int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe),
    .new_sample_pin_o(new_sample_pin_o), .new_sample_pin_oe(new_sample_pin_oe)
);

// ==== mic_ctrl_tb.sv ====
// Self-checking bench for mic_ctrl with random limits, data and modes.
// Assumes mic_ctrl_properties.sv is compiled alongside.
`timescale 1ns/10ps

module mic_ctrl_tb;
    import mic_pkg::*;
    logic clk = 1'h0, rst = 1'h1, sample_store = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    logic xfer_end = 1'h0;
    logic [MIC_XY_W-1:0] raw_x = '0, raw_y = '0, fx, fy;
    logic [MIC_Z_W-1:0] raw_z = '0, fz;
    logic [MIC_RES_W-1:0] raw_res = '0, fr;
    logic [2:0] axis_ovf = '0;
    logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata, rd, ctrl, pin, lo, hi, ef;
    logic int_o, int_oe, new_o, new_oe, int_lvl, new_lvl;
    logic [31:0] r;
    int err_count = 0, check_count = 0, seed = 32'h5a78, cyc = 0;

    mic_ctrl u_mic_ctrl (.clk(clk), .rst(rst), .sample_store(sample_store), .raw_x(raw_x),
        .raw_y(raw_y), .raw_z(raw_z), .raw_res(raw_res), .axis_ovf(axis_ovf),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .xfer_end(xfer_end), .field_x_value(fx), .field_y_value(fy),
        .field_z_value(fz), .plate_resistance_value(fr), .int_pin_o(int_o),
        .int_pin_oe(int_oe), .new_sample_pin_o(new_o), .new_sample_pin_oe(new_oe));
    mic_host u_mic_host (.clk(clk), .int_o(int_o), .int_oe(int_oe), .new_o(new_o),
        .new_oe(new_oe), .int_lvl(int_lvl), .new_lvl(new_lvl));

    initial
    begin
        forever #5 clk = ~clk;
    end

    // ****************************************
    // Expected flags and bus tasks
    // ****************************************
    function automatic logic [7:0] exp_flags();
        int v[3];
        logic [7:0] f;
        v[0] = int'($signed(axis_ovf[0] ? MIC_XY_SAT : raw_x));
        v[1] = int'($signed(axis_ovf[1] ? MIC_XY_SAT : raw_y));
        v[2] = int'($signed(axis_ovf[2] ? MIC_Z_SAT : raw_z));
        f = '0;
        for (int i = 0; i < 3; i++)
        begin
            f[i] = !ctrl[i] && v[i] < int'($signed(lo)) * 16 && !(i < 2 && v[i] == -4096);
            f[i+3] = !ctrl[i+3] && v[i] > int'($signed(hi)) * 16;
        end
        f[6] = ctrl[6] && |axis_ovf;
        return f;
    endfunction : exp_flags

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'h1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'h0;
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        @(negedge clk);
        reg_rd = 1'h1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'h0;
        rd = reg_rdata;
    endtask : rdr

    task automatic pulse_end();
        @(negedge clk);
        xfer_end = 1'h1;
        @(negedge clk);
        xfer_end = 1'h0;
    endtask : pulse_end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // Ceiling well above the roughly 1050 cycles the tests need
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            err_count++;
            print_verdict();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (5) @(negedge clk);
        rst = 1'h0;
        rdr(MIC_ADDR_CTRL); chk(rd, 8'h3f);
        rdr(MIC_ADDR_PIN); chk(rd, 8'h07);
        chk({int_oe, new_oe}, 2'h0);
        wr(MIC_ADDR_FLAGS, 8'hff);
        rdr(MIC_ADDR_FLAGS); chk(rd, 8'h00);
        $display("test reset done");
        for (int n = 0; n < 40; n++)
        begin
            // Latched mode first, so the status read drops flags left from the last pass
            wr(MIC_ADDR_PIN, 8'h02);
            rdr(MIC_ADDR_FLAGS);
            r = $random(seed);
            ctrl = r[7:0] & 8'h7f;
            pin = r[15:8] & 8'hc7;
            lo = r[23:16];
            hi = r[31:24];
            wr(MIC_ADDR_CTRL, ctrl);
            wr(MIC_ADDR_PIN, pin);
            wr(MIC_ADDR_LOWER, lo);
            wr(MIC_ADDR_UPPER, hi);
            @(negedge clk);
            r = $random(seed);
            raw_x = r[0] ? r[12:0] : {lo[7], lo, 4'h0} - {12'h0, r[1]};
            raw_y = r[2] ? r[15:3] : {hi[7], hi, 4'h0} + {12'h0, r[3]};
            raw_z = r[30:16];
            raw_res = r[13:0];
            axis_ovf = r[6:4] & r[9:7];
            sample_store = 1'h1;
            @(negedge clk);
            sample_store = 1'h0;
            ef = exp_flags();
            chk(fx, axis_ovf[0] ? MIC_XY_SAT : raw_x);
            chk(fy, axis_ovf[1] ? MIC_XY_SAT : raw_y);
            chk(fz, axis_ovf[2] ? MIC_Z_SAT : raw_z);
            chk(fr, raw_res);
            chk({int_oe, new_oe}, {pin[6], pin[7]});
            if (pin[6]) chk(int_lvl, pin[0] == |ef);
            if (pin[7]) chk(new_lvl, pin[2]);
            rdr(MIC_ADDR_FLAGS); chk(rd, ef);
            // Host releases a latched line before the next event
            if (pin[6]) chk(int_lvl, pin[0] == (|ef && !pin[1]));
            pulse_end();
            rdr(MIC_ADDR_RES_LSB); chk(rd, {raw_res[5:0], 2'h1});
            pulse_end();
            rdr(MIC_ADDR_RES_LSB); chk(rd[0], 1'h0);
            if (pin[7]) chk(new_lvl, !pin[2]);
            // Close the read so no pending data read clears the next sample's flag
            pulse_end();
        end
        $display("test random done");
        print_verdict();
    end
endmodule : mic_ctrl_tb

// ==== mic_host.sv ====
// Host side of the two interrupt pins: the levels the processor sees.
// Assumes no pull resistor on either line.
`timescale 1ns/10ps

module mic_host (
    // Clock
    input wire logic clk,
    // Device pins
    input wire logic int_o,
    input wire logic int_oe,
    input wire logic new_o,
    input wire logic new_oe,
    // Levels at the host
    output logic int_lvl,
    output logic new_lvl
);
    logic int_last_r, new_last_r;
    always_ff @(posedge clk)
    begin
        if (int_oe)
            int_last_r <= int_o;
        if (new_oe)
            new_last_r <= new_o;
    end
    // A floating line must not look like a held level
    assign int_lvl = int_oe ? int_o : ~int_last_r;
    assign new_lvl = new_oe ? new_o : ~new_last_r;
endmodule : mic_host

// ==== mic_pkg.sv ====
// Package for the magnetometer interrupt controller: register offsets,
// field positions, reset values and widths.
// Assumes an 8-bit register port driven by the sensor's serial interface.
package mic_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] MIC_ADDR_DATA_LO = 8'h42;
    localparam logic [7:0] MIC_ADDR_RES_LSB = 8'h48;
    localparam logic [7:0] MIC_ADDR_FLAGS = 8'h4a;
    localparam logic [7:0] MIC_ADDR_CTRL = 8'h4d;
    localparam logic [7:0] MIC_ADDR_PIN = 8'h4e;
    localparam logic [7:0] MIC_ADDR_LOWER = 8'h4f;
    localparam logic [7:0] MIC_ADDR_UPPER = 8'h50;

    // ************************************************************
    // Field positions
    // ************************************************************
    // Control register 0x4d
    localparam int MIC_CTRL_OVF_EN = 6;
    localparam int MIC_CTRL_AXIS_LO = 0;
    localparam int MIC_CTRL_AXIS_HI = 3;
    // Pin register 0x4e
    localparam int MIC_PIN_NEW_EN = 7;
    localparam int MIC_PIN_INT_EN = 6;
    localparam int MIC_PIN_NEW_POL = 2;
    localparam int MIC_PIN_LATCH = 1;
    localparam int MIC_PIN_INT_POL = 0;
    // Flags register 0x4a: low flags x,y,z at 0..2, high at 3..5
    localparam int MIC_FLG_LOW = 0;
    localparam int MIC_FLG_HIGH = 3;
    localparam int MIC_FLG_OVF = 6;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] MIC_CTRL_RST = 8'h3f;
    localparam logic [7:0] MIC_PIN_RST = 8'h07;
    localparam logic [7:0] MIC_LIMIT_RST = 8'h00;

    // ************************************************************
    // Data widths and saturation codes
    // ************************************************************
    localparam int MIC_XY_W = 13;
    localparam int MIC_Z_W = 15;
    localparam int MIC_RES_W = 14;
    localparam int MIC_THR_SHIFT = 4;
    localparam logic [MIC_XY_W-1:0] MIC_XY_SAT = 13'h1000;
    localparam logic [MIC_Z_W-1:0] MIC_Z_SAT = 15'h4000;

endpackage : mic_pkg
